// ---- rtl/sadc_host.sv ----
/*
  Host end: on a request, pulses start, waits out the conversion, selects
  the device, clocks eighteen bits by a divider and queues the word.
  Assumes the far end is a converter on the link.
*/
`timescale 1ns/1ps
`include "sadc_consts.svh"
module sadc_host
  import sadc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  sadc_if.host lnk,
  input wire sadc_pkg::sadc_mode_e mode,
  input wire logic req,
  output logic req_ready,
  output logic res_valid,
  input wire logic res_ready,
  output sadc_pkg::sadc_word_t res_data
);
  import sadc_pkg::*;
  typedef enum logic [2:0] {
    SADC_H_IDLE = 3'h0, SADC_H_CNVH = 3'h1, SADC_H_WAIT = 3'h3,
    SADC_H_SEL = 3'h2, SADC_H_SHIFT = 3'h6, SADC_H_END = 3'h7
  } sadc_hst_e;
  sadc_hst_e st_q;
  logic [`SADC_CNT_W-1:0] cnt_q;
  logic [4:0] bits_q;
  sadc_word_t sh_q;
  logic cnv_q, sdi_q, sclk_q, push_q, fifo_rdy;
  logic [2:0] sdo_s;
  logic four_w;
  assign four_w = mode == SADC_M4W || mode == SADC_M4W_BSY;
  always_ff @(posedge mclk) begin
    if (rst) sdo_s <= '0;
    else sdo_s <= {sdo_s[1:0], lnk.sdo};
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_q <= SADC_H_IDLE;
      cnt_q <= '0;
      bits_q <= '0;
      cnv_q <= 1'b0;
      sdi_q <= 1'b1;
      sclk_q <= 1'b0;
      sh_q <= '0;
      push_q <= 1'b0;
    end else begin
      push_q <= 1'b0;
      cnt_q <= cnt_q + 1'b1;
      case (st_q)
        SADC_H_IDLE: begin
          cnt_q <= '0;
          if (req && fifo_rdy) begin
            cnv_q <= 1'b1;
            st_q <= SADC_H_CNVH;
          end
        end
        SADC_H_CNVH: begin
          // Start held high through both high and low counts; 4-wire drops it at the end
          if (cnt_q == `SADC_CNT_W'(`SADC_CNVH_CYC + `SADC_CNVL_CYC)) begin
            if (!four_w) cnv_q <= 1'b1;
            cnt_q <= '0;
            st_q <= SADC_H_WAIT;
          end
        end
        SADC_H_WAIT: begin
          // No read until conversion is over
          if (cnt_q == `SADC_CNT_W'(`SADC_CONV_CYC + 8)) begin
            cnt_q <= '0;
            if (four_w) sdi_q <= 1'b0;
            else cnv_q <= 1'b0;
            st_q <= SADC_H_SEL;
          end
        end
        SADC_H_SEL: begin
          if (cnt_q == `SADC_CNT_W'(`SADC_SCLK_DIV)) begin
            cnt_q <= '0;
            sh_q <= {sh_q[`SADC_RES_W-2:0], sdo_s[1]};
            bits_q <= 5'h1;
            sclk_q <= 1'b1;
            st_q <= SADC_H_SHIFT;
          end
        end
        SADC_H_SHIFT: begin
          if (cnt_q == `SADC_CNT_W'(`SADC_SCLK_DIV)) begin
            cnt_q <= '0;
            sclk_q <= !sclk_q;
            if (sclk_q && bits_q == 5'(`SADC_RES_W)) begin
              st_q <= SADC_H_END;
            end else if (!sclk_q) begin
              // Sample before rising, after device settled
              sh_q <= {sh_q[`SADC_RES_W-2:0], sdo_s[1]};
              bits_q <= bits_q + 5'h1;
            end
          end
        end
        default: begin
          if (cnt_q == `SADC_CNT_W'(`SADC_CNVL_CYC)) begin
            sdi_q <= 1'b1;
            cnv_q <= 1'b0;
            push_q <= 1'b1;
            st_q <= SADC_H_IDLE;
          end
        end
      endcase
      if (st_q == SADC_H_CNVH && cnt_q == `SADC_CNT_W'(`SADC_CNVL_CYC))
        cnv_q <= 1'b1;
      else if (st_q == SADC_H_CNVH && four_w &&
        cnt_q == `SADC_CNT_W'(`SADC_CNVL_CYC + `SADC_CNVH_CYC))
        cnv_q <= 1'b0;
    end
  end
  assign lnk.conv_start_select = cnv_q;
  assign lnk.sdi = sdi_q;
  assign lnk.sclk = sclk_q;
  assign req_ready = st_q == SADC_H_IDLE && fifo_rdy;
  sadc_fifo #(.W(`SADC_RES_W), .D(`SADC_FIFO_DEPTH), .AW(`SADC_FIFO_AW))
    u_fifo (
    .mclk(mclk),
    .rst(rst),
    .in_valid(push_q),
    .in_ready(fifo_rdy),
    .in_data(sh_q),
    .out_valid(res_valid),
    .out_ready(res_ready),
    .out_data(res_data)
  );
endmodule // sadc_host

// ---- rtl/sadc_consts.svh ----
/*
  Constants for the converter serial readout link: timing counts at the
  200 MHz system clock, result width, counter width, serial clock divider, FIFO depth.
  Assumes both ends share mclk and the same constants.
*/
`ifndef SADC_CONSTS_SVH
`define SADC_CONSTS_SVH
`define SADC_CLK_PS 5000
`define SADC_RES_W 18
`define SADC_CNT_W 8
`define SADC_T_CNVH_PS 10000
`define SADC_CNVH_CYC ((`SADC_T_CNVH_PS + `SADC_CLK_PS - 1) / `SADC_CLK_PS)
`define SADC_T_CNVL_PS 20000
`define SADC_CNVL_CYC ((`SADC_T_CNVL_PS + `SADC_CLK_PS - 1) / `SADC_CLK_PS)
`define SADC_T_CONV_PS 500000
`define SADC_CONV_CYC ((`SADC_T_CONV_PS + `SADC_CLK_PS - 1) / `SADC_CLK_PS)
`define SADC_T_ACQ_PS 290000
`define SADC_ACQ_CYC ((`SADC_T_ACQ_PS + `SADC_CLK_PS - 1) / `SADC_CLK_PS)
`define SADC_SCLK_DIV 13
`define SADC_FIFO_DEPTH 8
`define SADC_FIFO_AW 3
`endif

// ---- rtl/sadc_pkg.sv ----
/*
  Types for the converter readout link.
  Assumes sadc_consts.svh is on the include path.
*/
`include "sadc_consts.svh"
package sadc_pkg;
  typedef enum logic [2:0] {
    SADC_M3W = 3'h0, SADC_M3W_BSY = 3'h1, SADC_M4W = 3'h2,
    SADC_M4W_BSY = 3'h3, SADC_MDC = 3'h4, SADC_MDC_BSY = 3'h5
  } sadc_mode_e;
  typedef logic [`SADC_RES_W-1:0] sadc_word_t;
endpackage

// ---- rtl/sadc_if.sv ----
/*
  Link between converter end and host end: start, select, serial clock and
  a three-state data output. Resolves the data wire from its enable.
*/
`timescale 1ns/1ps
interface sadc_if;
  logic conv_start_select;
  logic sdi;
  logic sclk;
  logic sdo_o;
  logic sdo_oe;
  wire sdo;
  // Released line reads low, standing in for a weak pull-down
  assign sdo = sdo_oe ? sdo_o : 1'b0;
  modport dev (input conv_start_select, input sdi, input sclk,
    output sdo_o, output sdo_oe);
  modport host (output conv_start_select, output sdi, output sclk,
    input sdo);
endinterface

// ---- rtl/sadc_fifo.sv ----
/*
  Small flop FIFO with valid/ready both sides.
  Single clock domain.
*/
`timescale 1ns/1ps
`include "sadc_consts.svh"
module sadc_fifo #(
  parameter int W = `SADC_RES_W,
  parameter int D = `SADC_FIFO_DEPTH,
  parameter int AW = `SADC_FIFO_AW
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  logic [W-1:0] mem_q [D];
  logic [AW-1:0] wr_q, rd_q;
  logic [AW:0] cnt_q;
  logic push, pop;
  assign in_ready = cnt_q != D[AW:0];
  assign out_valid = cnt_q != '0;
  assign out_data = mem_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always_ff @(posedge mclk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop) rd_q <= rd_q + 1'b1;
      cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule // sadc_fifo

// ---- rtl/sadc_dev.sv ----
/*
  Converter end: starts a conversion on the start line's rise, converts on
  its own timer, then shifts the result out under the host serial clock.
  Assumes all link inputs are asynchronous to mclk.
*/
`timescale 1ns/1ps
`include "sadc_consts.svh"
module sadc_dev
  import sadc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  sadc_if.dev lnk,
  input wire sadc_pkg::sadc_mode_e mode,
  input wire sadc_pkg::sadc_word_t sample,
  output logic busy,
  output logic low_power
);
  import sadc_pkg::*;
  typedef enum logic [1:0] {
    SADC_D_ACQ = 2'h0, SADC_D_CONV = 2'h1, SADC_D_DONE = 2'h3
  } sadc_dst_e;
  sadc_dst_e st_q;
  logic [2:0] cnv_s, sdi_s, clk_s;
  logic [`SADC_CNT_W-1:0] cnt_q;
  sadc_word_t sh_q;
  logic [4:0] left_q;
  logic oe_q, do_q, busy_q, lp_q, fall, cnv_rise, sel_n, sel_n_d;
  always_ff @(posedge mclk) begin
    if (rst) begin
      cnv_s <= '0;
      sdi_s <= 3'h7;
      clk_s <= '0;
    end else begin
      cnv_s <= {cnv_s[1:0], lnk.conv_start_select};
      sdi_s <= {sdi_s[1:0], lnk.sdi};
      clk_s <= {clk_s[1:0], lnk.sclk};
    end
  end
  assign cnv_rise = cnv_s[1] && !cnv_s[2];
  assign fall = !clk_s[1] && clk_s[2];
  // Select low opens the output
  assign sel_n = (mode == SADC_M4W || mode == SADC_M4W_BSY) ?
    sdi_s[1] : cnv_s[1];
  assign sel_n_d = (mode == SADC_M4W || mode == SADC_M4W_BSY) ?
    sdi_s[2] : cnv_s[2];
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_q <= SADC_D_ACQ;
      cnt_q <= '0;
      sh_q <= '0;
    end else begin
      case (st_q)
        SADC_D_ACQ: begin
          if (cnv_rise) begin
            st_q <= SADC_D_CONV;
            cnt_q <= '0;
          end
        end
        SADC_D_CONV: begin
          // Internal timer only; serial clock ignored here
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == `SADC_CNT_W'(`SADC_CONV_CYC - 1)) begin
            sh_q <= sample;
            st_q <= SADC_D_DONE;
          end
        end
        default: begin
          if (cnv_rise) begin
            st_q <= SADC_D_CONV;
            cnt_q <= '0;
          end
        end
      endcase
    end
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      lp_q <= 1'b1;
      busy_q <= 1'b0;
    end else begin
      lp_q <= st_q != SADC_D_CONV;
      busy_q <= st_q == SADC_D_CONV;
    end
  end
  // Output path: MSB at select fall, shift on each serial clock fall
  always_ff @(posedge mclk) begin
    if (rst) begin
      oe_q <= 1'b0;
      do_q <= 1'b0;
      left_q <= '0;
    end else if (sel_n || st_q != SADC_D_DONE) begin
      oe_q <= 1'b0;
      left_q <= '0;
    end else if (sel_n_d) begin
      oe_q <= 1'b1;
      do_q <= sh_q[`SADC_RES_W-1];
      left_q <= 5'(`SADC_RES_W - 1);
    end else if (fall && oe_q) begin
      // Shift lands two syncs after the edge: bit held well past 3 ns
      if (left_q == '0) begin
        oe_q <= 1'b0;
      end else begin
        do_q <= sh_q[left_q - 5'h1];
        left_q <= left_q - 5'h1;
      end
    end
  end
  // Daisy modes read out on the 3-wire select path
  assign lnk.sdo_o = do_q;
  assign lnk.sdo_oe = oe_q;
  assign busy = busy_q;
  assign low_power = lp_q;
endmodule // sadc_dev

// ---- tb/sadc_chk.sv ----
/*
  Checker on the readout link wires, mode and converter status.
  Assumes one mclk domain and the link inputs seen as plain signals.
*/
`timescale 1ns/1ps
module sadc_chk
  import sadc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire sadc_pkg::sadc_mode_e mode,
  input wire logic conv_start_select,
  input wire logic sdi,
  input wire logic sclk,
  input wire logic sdo_o,
  input wire logic sdo_oe,
  input wire logic busy,
  input wire logic low_power
);
  import sadc_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  logic w4;
  assign w4 = (mode == SADC_M4W) || (mode == SADC_M4W_BSY);
  AST_START_HI: assert property (
    $rose(conv_start_select) |-> conv_start_select[*2])
    else $error("start pulse short");
  AST_START_LO: assert property (
    w4 && $fell(conv_start_select) |-> (!conv_start_select)[*4])
    else $error("start low time short");
  AST_SEL_HI: assert property (w4 && $rose(sdi) |-> sdi[*2])
    else $error("select high time short");
  AST_REL_3W: assert property (
    !w4 && $rose(conv_start_select) |-> ##[0:3] !sdo_oe)
    else $error("output not released");
  AST_MSB_3W: assert property (
    !w4 && $fell(conv_start_select) |-> ##[1:3] sdo_oe)
    else $error("output not enabled");
  AST_REL_4W: assert property (w4 && $rose(sdi) |-> ##[0:3] !sdo_oe)
    else $error("output not released");
  AST_MSB_4W: assert property (w4 && $fell(sdi) |-> ##[1:3] sdo_oe)
    else $error("output not enabled");
  AST_HOLD: assert property ($fell(sclk) && sdo_oe |=> $stable(sdo_o))
    else $error("bit not held");
  AST_CONV: assert property (
    $rose(conv_start_select) |-> ##[1:5] busy)
    else $error("conversion not started");
  AST_QUIET: assert property (busy && $past(busy, 4) |-> !sdo_oe)
    else $error("output driven while converting");
  AST_POWER: assert property (low_power != busy)
    else $error("power state wrong");
  AST_READ_LP: assert property (sdo_oe |-> low_power && !busy)
    else $error("readout outside acquisition");
  cover property (w4 && $rose(sdi));
  cover property (!w4 && $fell(sdo_oe));
  cover property ($fell(busy));
endmodule // sadc_chk

// ---- tb/tb_sar_adc_serial_readout_timing.sv ----
/*
  Bench: converter end and host end on one link, all six modes, FIFO fill.
  Assumes the package is compiled first.
*/
`timescale 1ns/1ps
module tb_sar_adc_serial_readout_timing;
  import sadc_pkg::*;
  logic mclk, rst, req, res_ready, req_ready, res_valid, busy, low_power;
  logic sclk_q, oe_q;
  sadc_mode_e mode;
  sadc_word_t sample, res_data, wword;
  sadc_word_t eq[$];
  sadc_word_t wq[$];
  int err_count, total_checks, nbits;
  sadc_if lnk();
  sadc_dev i_sadc_dev(.mclk(mclk), .rst(rst), .lnk(lnk), .mode(mode),
    .sample(sample), .busy(busy), .low_power(low_power));
  sadc_host i_sadc_host(.mclk(mclk), .rst(rst), .lnk(lnk), .mode(mode),
    .req(req), .req_ready(req_ready), .res_valid(res_valid),
    .res_ready(res_ready), .res_data(res_data));
  sadc_chk i_sadc_chk(.mclk(mclk), .rst(rst), .mode(mode),
    .conv_start_select(lnk.conv_start_select), .sdi(lnk.sdi),
    .sclk(lnk.sclk), .sdo_o(lnk.sdo_o), .sdo_oe(lnk.sdo_oe),
    .busy(busy), .low_power(low_power));
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  task automatic check(input string nm, input sadc_word_t seen,
    input sadc_word_t exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic tick();
    @(posedge mclk);
    #1;
  endtask
  // Bounded wait; a hang ends the run
  task automatic wait_hi(ref logic s, input int lim);
    int n;
    n = 0;
    while (s !== 1'b1 && n < lim) begin
      tick();
      n++;
    end
    if (s !== 1'b1) begin
      err_count++;
      $display("Error handshake expected 1 seen %b", s);
      complete_run();
    end
  endtask
  // Sample held until next request: a start rise restarts conversion
  task automatic convert(input sadc_word_t v);
    wait_hi(req_ready, 5000);
    sample = v;
    eq.push_back(v);
    wq.push_back(v);
    req = 1'b1;
    tick();
    req = 1'b0;
  endtask
  task automatic fetch();
    wait_hi(res_valid, 20000);
    check("res_data", res_data, eq.pop_front());
    res_ready = 1'b1;
    tick();
    res_ready = 1'b0;
    tick();
  endtask
  // Wire side: bits taken on serial clock falls, MSB first
  always @(posedge mclk) begin
    sclk_q <= lnk.sclk;
    oe_q <= lnk.sdo_oe;
    if (sclk_q && !lnk.sclk && lnk.sdo_oe) begin
      wword <= {wword[16:0], lnk.sdo};
      nbits <= nbits + 1;
    end
    if (oe_q && !lnk.sdo_oe) begin
      check("wire_word", wword, wq.pop_front());
      check("wire_bits", sadc_word_t'(nbits), 18'h00012);
      nbits <= 0;
    end
  end
  initial begin
    rst = 1'b1;
    req = 1'b0;
    res_ready = 1'b0;
    sample = '0;
    wword = '0;
    mode = SADC_M3W;
    err_count = 0;
    total_checks = 0;
    nbits = 0;
    sclk_q = 1'b0;
    oe_q = 1'b0;
    repeat (12) @(posedge mclk);
    #1 rst = 1'b0;
    for (int m = 0; m < 6; m++) begin
      mode = sadc_mode_e'(3'(m));
      convert(18'h20000 + 18'(m));
      convert(18'h1FFFF - 18'(m));
      fetch();
      fetch();
      repeat (8) tick();
    end
    // Fill the FIFO with the reader stalled, then drain it
    mode = SADC_M4W;
    for (int k = 0; k < 8; k++)
      convert(18'h2A5A5 ^ 18'(k * 2049));
    repeat (1500) tick();
    check("req_ready_full", 18'(req_ready), 18'h00000);
    for (int k = 0; k < 8; k++)
      fetch();
    check("res_valid_empty", 18'(res_valid), 18'h00000);
    check("wire_left", 18'(wq.size()), 18'h00000);
    complete_run();
  end
endmodule // tb_sar_adc_serial_readout_timing
